// file: rtl/dbc_pkg.sv
// Constants and types shared by the DRAM buffer control block.
package dbc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] DBC_REG_CONFIG = 8'h00;
    localparam logic [7:0] DBC_REG_STATUS = 8'h04;
    localparam logic [1:0] DBC_RESP_OKAY = 2'h0;
    localparam logic [1:0] DBC_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------
    localparam int DBC_MODE_LSB = 0;
    localparam int DBC_MODE_W = 2;
    localparam int DBC_DENS_LSB = 12;
    localparam int DBC_DENS_W = 3;
    localparam logic [2:0] DBC_DENS_RESET = 3'h0;
    localparam logic [2:0] DBC_DENS_SPLIT = 3'h4;

    // ------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------
    localparam int DBC_ST_ACTIVE = 0;
    localparam int DBC_ST_WRITE = 1;
    localparam int DBC_ST_BANK = 2;
    localparam int DBC_ST_NEXT = 3;
    localparam int DBC_ST_BLOCK_LSB = 4;

    // ------------------------------------------------------------
    // Memory addressing
    // ------------------------------------------------------------
    localparam int DBC_MEM_ADDR_W = 12;
    localparam int DBC_COL_BITS_MIN = 9;
    localparam int DBC_BANK_BIT = 2;
    localparam int DBC_BLOCKS = 4;

    typedef enum logic [1:0] {
        DBC_MODE_TX_PER_BANK = 2'h0,
        DBC_MODE_CE_PER_BANK = 2'h1,
        DBC_MODE_TX_SHARED = 2'h2,
        DBC_MODE_CE_SHARED = 2'h3
    } dbc_mode_t;

endpackage : dbc_pkg

// file: rtl/dbc_buffer_ctrl.sv
// Buffer, write strobe and row strobe control for a two-bank interleaved DRAM controller.
//
// Behaviour
// R01: Mode 0: per-bank read drive, write strobes.
// R02: Mode 1: per-bank buffer select on any access.
// R03: Mode 1: write strobes low only on writes.
// R04: Mode 2: one shared read drive enable.
// R05: Mode 2: per-bank write strobes as mode 0.
// R06: Mode 2: next-bank select for reads.
// R07: Mode 3: one shared buffer select, all accesses.
// R08: Mode 3: next-bank select chooses read bank.
// R09: Mode 3: both write strobes together.
// R10: Density 0-3: four bank row strobes together.
// R11: Density 4-7: one row strobe per module.
// R12: Four blocks, one row strobe pair each.
// R13: Address multiplexing up to 16M by 4.
// R14: Host region: burst, ready, no pipelining, 32-bit.
// R15: Software disables burst writes when unlatched.
// R16: Next-bank high selects bank B next edge.
// R17: Per-bank active-low write latch enables.
// R18: Reset: mode 0, controls idle high.
// R19: Next-bank select registered on the clock.
`timescale 1ns/1ps
`default_nettype none

module dbc_buffer_ctrl
    import dbc_pkg::*;
#(
    parameter int AXI_ADDR_W = 8,
    parameter int HOST_ADDR_W = 32
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Access state from the controller core
    input wire logic acc_active,
    input wire logic acc_write,
    input wire logic acc_bank_b,
    input wire logic acc_next_bank_b,
    input wire logic [1:0] acc_block,
    input wire logic acc_row_strobe,
    input wire logic acc_col_phase,
    input wire logic acc_latch_hold,
    input wire logic [HOST_ADDR_W-1:0] acc_addr,
    // Buffer control pins
    output logic buffer_ctrl_first_n,
    output logic buffer_ctrl_second,
    output logic [1:0] bank_write_strobe_n,
    output logic write_latch_enable_first_n,
    output logic write_latch_enable_second_n,
    // Memory pins
    output logic [DBC_BLOCKS-1:0] row_strobe_a_n,
    output logic [DBC_BLOCKS-1:0] row_strobe_b_n,
    output logic [DBC_MEM_ADDR_W-1:0] mem_addr
);

    // ------------------------------------------------------------
    // Configuration and bus slave
    // ------------------------------------------------------------
    dbc_mode_t buffer_mode;
    logic [DBC_DENS_W-1:0] density;
    logic aw_held;
    logic w_held;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_bank_select;
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic [AXI_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] status_word;
    logic [31:0] config_word;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_fire = (aw_held || aw_take) && (w_held || w_take) && !s_axi_bvalid;
    assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    assign wr_data = w_held ? w_data : s_axi_wdata;
    assign wr_strb = w_held ? w_strb : s_axi_wstrb;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end else if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end else if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
    end

    // Mode and density fields live in separate byte lanes so each can be written alone.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            buffer_mode <= DBC_MODE_TX_PER_BANK; // [R18]
            density <= DBC_DENS_RESET;
        end else if (wr_fire && wr_addr == DBC_REG_CONFIG[AXI_ADDR_W-1:0]) begin
            if (wr_strb[0]) begin
                buffer_mode <= dbc_mode_t'(wr_data[DBC_MODE_LSB +: DBC_MODE_W]);
            end
            if (wr_strb[1]) begin
                density <= wr_data[DBC_DENS_LSB +: DBC_DENS_W];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= DBC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (wr_addr == DBC_REG_CONFIG[AXI_ADDR_W-1:0]
                    || wr_addr == DBC_REG_STATUS[AXI_ADDR_W-1:0]) begin
                s_axi_bresp <= DBC_RESP_OKAY;
            end else begin
                s_axi_bresp <= DBC_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_comb begin
        config_word = '0;
        config_word[DBC_MODE_LSB +: DBC_MODE_W] = buffer_mode;
        config_word[DBC_DENS_LSB +: DBC_DENS_W] = density;
        status_word = '0;
        status_word[DBC_ST_ACTIVE] = acc_active;
        status_word[DBC_ST_WRITE] = acc_write;
        status_word[DBC_ST_BANK] = acc_bank_b;
        status_word[DBC_ST_NEXT] = next_bank_select;
        status_word[DBC_ST_BLOCK_LSB +: 2] = acc_block;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= DBC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= DBC_RESP_OKAY;
            if (s_axi_araddr == DBC_REG_CONFIG[AXI_ADDR_W-1:0]) begin
                s_axi_rdata <= config_word;
            end else if (s_axi_araddr == DBC_REG_STATUS[AXI_ADDR_W-1:0]) begin
                s_axi_rdata <= status_word;
            end else begin
                s_axi_rdata <= '0;
                s_axi_rresp <= DBC_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Buffer and write controls
    // ------------------------------------------------------------
    logic rd_a;
    logic rd_b;
    logic wr_a;
    logic wr_b;
    logic next_first_n;
    logic next_second;
    logic [1:0] next_we_n;

    assign rd_a = acc_active && !acc_write && !acc_bank_b;
    assign rd_b = acc_active && !acc_write && acc_bank_b;
    assign wr_a = acc_active && acc_write && !acc_bank_b;
    assign wr_b = acc_active && acc_write && acc_bank_b;

    // Idle decodes to all ones except the mode 2 and 3 next-bank select, so every active-low control rests high.
    always_comb begin
        next_we_n = {!wr_b, !wr_a}; // [R01] [R03] [R05]
        next_first_n = 1'b1;
        next_second = 1'b1;
        unique case (buffer_mode)
            DBC_MODE_TX_PER_BANK: begin
                next_first_n = !rd_a; // [R01]
                next_second = !rd_b; // [R01]
            end
            DBC_MODE_CE_PER_BANK: begin
                next_first_n = !(rd_a || wr_a); // [R02]
                next_second = !(rd_b || wr_b); // [R02]
            end
            DBC_MODE_TX_SHARED: begin
                next_first_n = !(rd_a || rd_b); // [R04]
                next_second = acc_next_bank_b; // [R06]
            end
            DBC_MODE_CE_SHARED: begin
                next_first_n = !acc_active; // [R07]
                next_second = acc_next_bank_b; // [R08]
                next_we_n = {2{!(wr_a || wr_b)}}; // [R09]
            end
        endcase
    end

    // Registered pins keep the clock-to-output delay of the bank select small.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            buffer_ctrl_first_n <= 1'b1; // [R18]
            buffer_ctrl_second <= 1'b1;
            bank_write_strobe_n <= 2'h3;
        end else begin
            buffer_ctrl_first_n <= next_first_n;
            buffer_ctrl_second <= next_second; // [R19]
            bank_write_strobe_n <= next_we_n;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            next_bank_select <= 1'b0;
        end else begin
            next_bank_select <= acc_next_bank_b; // [R16] [R19]
        end
    end

    // Latches are open while write data flows and close when the core holds them.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            write_latch_enable_first_n <= 1'b1;
            write_latch_enable_second_n <= 1'b1;
        end else begin
            write_latch_enable_first_n <= !(wr_a && !acc_latch_hold); // [R17]
            write_latch_enable_second_n <= !(wr_b && !acc_latch_hold); // [R17]
        end
    end

    // ------------------------------------------------------------
    // Row strobes and address multiplexing
    // ------------------------------------------------------------
    logic [DBC_BLOCKS-1:0] strobe_set;
    logic [31:0] word_addr;
    logic [31:0] col_full;
    logic [31:0] row_full;
    int col_bits;

    always_comb begin
        if (density < DBC_DENS_SPLIT) begin
            strobe_set = {DBC_BLOCKS{1'b1}}; // [R10]
        end else begin
            strobe_set = '0;
            strobe_set[acc_block] = 1'b1; // [R11] [R12]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            row_strobe_a_n <= '1;
            row_strobe_b_n <= '1;
        end else begin
            row_strobe_a_n <= ~(strobe_set & {DBC_BLOCKS{acc_row_strobe && !acc_bank_b}});
            row_strobe_b_n <= ~(strobe_set & {DBC_BLOCKS{acc_row_strobe && acc_bank_b}});
        end
    end

    // The low two density bits pick 9 to 12 column bits, reaching 16M-deep parts.
    always_comb begin
        col_bits = DBC_COL_BITS_MIN + int'(density[1:0]); // [R13]
        word_addr = 32'(acc_addr) >> (DBC_BANK_BIT + 1);
        col_full = word_addr & ((32'h1 << col_bits) - 32'h1);
        row_full = word_addr >> col_bits;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mem_addr <= '0;
        end else if (acc_col_phase) begin
            mem_addr <= col_full[DBC_MEM_ADDR_W-1:0]; // [R13]
        end else begin
            mem_addr <= row_full[DBC_MEM_ADDR_W-1:0];
        end
    end

endmodule : dbc_buffer_ctrl

`default_nettype wire

// file: dv/dbc_buffer_ctrl_chk.sv
// Concurrent checks on the buffer control pins.
`timescale 1ns/1ps
`default_nettype none
module dbc_buffer_ctrl_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Access state
    input wire logic acc_active,
    input wire logic acc_write,
    input wire logic acc_bank_b,
    input wire logic [1:0] acc_block,
    input wire logic acc_row_strobe,
    input wire logic acc_latch_hold,
    // Pins
    input wire logic buffer_ctrl_first_n,
    input wire logic [1:0] bank_write_strobe_n,
    input wire logic write_latch_enable_first_n,
    input wire logic [dbc_pkg::DBC_BLOCKS-1:0] row_strobe_a_n,
    input wire logic [dbc_pkg::DBC_BLOCKS-1:0] row_strobe_b_n
);
    import dbc_pkg::*;
    // ---
    // Checks
    // ---
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    a_strobe_cause: assert property (
        bank_write_strobe_n != 2'h3 |-> $past(acc_active && acc_write))
        else $error("write strobe without a write");
    a_strobe_bank: assert property (
        $past(acc_active && acc_write && !srst) |-> !bank_write_strobe_n[$past(acc_bank_b)])
        else $error("write strobe missing");
    a_latch_cause: assert property (
        !write_latch_enable_first_n |-> $past(acc_active && acc_write && !acc_bank_b))
        else $error("latch open without a write");
    a_latch_open: assert property (
        $past(acc_active && acc_write && !acc_bank_b && !acc_latch_hold && !srst)
        |-> !write_latch_enable_first_n)
        else $error("latch not open");
    a_idle_high: assert property (
        $past(!acc_active) |-> buffer_ctrl_first_n)
        else $error("buffer control low while idle");
    a_rows_idle: assert property (
        $past(!acc_row_strobe) |-> &{row_strobe_a_n, row_strobe_b_n})
        else $error("row strobe low while idle");
    a_rows_block: assert property (
        $past(acc_row_strobe && !acc_bank_b && !srst) |-> !row_strobe_a_n[$past(acc_block)])
        else $error("block row strobe missing");
    a_reset_idle: assert property (
        $past(srst) |-> {buffer_ctrl_first_n, bank_write_strobe_n, row_strobe_a_n} == 7'h7f)
        else $error("pins not idle after reset");
endmodule : dbc_buffer_ctrl_chk

bind dbc_buffer_ctrl dbc_buffer_ctrl_chk u_chk (.ref_clk, .srst, .acc_active, .acc_write,
    .acc_bank_b, .acc_block, .acc_row_strobe, .acc_latch_hold, .buffer_ctrl_first_n,
    .bank_write_strobe_n, .write_latch_enable_first_n, .row_strobe_a_n, .row_strobe_b_n);
`default_nettype wire

// file: dv/dbc_mem_model.sv
// Model of the data buffers and DRAM banks.
`timescale 1ns/1ps
`default_nettype none
module dbc_mem_model (
    // Controls
    input wire logic ref_clk,
    input wire logic first_n,
    input wire logic second,
    input wire logic [1:0] wstrobe_n,
    // Bank driving the data bus
    output logic [1:0] drive
);
    logic sel_b;
    // The select takes effect only from the next edge, as real output enables would.
    always_ff @(posedge ref_clk) begin
        sel_b <= second;
    end
    assign drive = (!first_n && &wstrobe_n) ? (sel_b ? 2'h2 : 2'h1) : 2'h0;
endmodule : dbc_mem_model
`default_nettype wire

// file: dv/dbc_buffer_ctrl_test.sv
// Self-checking testbench of the DRAM buffer control block.
`timescale 1ns/1ps
`default_nettype none
module dbc_buffer_ctrl_test;
    import dbc_pkg::*;
    // ---
    // Signals
    // ---
    logic ref_clk = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, acc_active = 0, acc_write = 0, acc_bank_b = 0;
    logic acc_next_bank_b = 0, acc_row_strobe = 0, acc_col_phase = 0, acc_latch_hold = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic buffer_ctrl_first_n, buffer_ctrl_second, write_latch_enable_first_n;
    logic write_latch_enable_second_n;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, acc_addr = 32'h0, s_axi_rdata, rd;
    logic [1:0] acc_block = 2'h0, s_axi_bresp, s_axi_rresp, bank_write_strobe_n, drive, rsp;
    logic [3:0] row_strobe_a_n, row_strobe_b_n;
    logic [11:0] mem_addr;
    int miscompares = 0, comparisons = 0;
    always #2 ref_clk = ~ref_clk;
    dbc_buffer_ctrl u_dut (.ref_clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .acc_active, .acc_write, .acc_bank_b, .acc_next_bank_b, .acc_block,
        .acc_row_strobe, .acc_col_phase, .acc_latch_hold, .acc_addr, .buffer_ctrl_first_n,
        .buffer_ctrl_second, .bank_write_strobe_n, .write_latch_enable_first_n,
        .write_latch_enable_second_n, .row_strobe_a_n, .row_strobe_b_n, .mem_addr);
    dbc_mem_model u_mem (.ref_clk, .first_n(buffer_ctrl_first_n),
        .second(buffer_ctrl_second), .wstrobe_n(bank_write_strobe_n), .drive);
    // ---
    // Tasks
    // ---
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic close_out;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, wd;
        ad = 0;
        wd = 0;
        @(posedge ref_clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge ref_clk);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            @(posedge ref_clk);
            if (ad) s_axi_awvalid <= 1'b0;
            if (wd) s_axi_wvalid <= 1'b0;
        end
        do @(negedge ref_clk); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        @(posedge ref_clk);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rdreg(input logic [7:0] a);
        @(posedge ref_clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do @(negedge ref_clk); while (s_axi_arready !== 1'b1);
        @(posedge ref_clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge ref_clk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge ref_clk);
        s_axi_rready <= 1'b0;
    endtask : rdreg
    task automatic set_cfg(input logic [1:0] m, input logic [2:0] dn);
        wr(DBC_REG_CONFIG, {17'h0, dn, 10'h0, m});
        chk("config_bresp", DBC_RESP_OKAY, rsp);
    endtask : set_cfg
    // One unpipelined single access at a time, as a host with burst writes off would issue.
    task automatic acc(input logic w, b, n, input logic [1:0] k, input logic r, h);
        @(posedge ref_clk);
        acc_active <= 1'b1;
        acc_write <= w;
        acc_bank_b <= b;
        acc_next_bank_b <= n;
        acc_block <= k;
        acc_row_strobe <= r;
        acc_latch_hold <= h;
        @(posedge ref_clk);
        acc_active <= 1'b0;
        acc_write <= 1'b0;
        acc_row_strobe <= 1'b0;
        #1;
    endtask : acc
    // ---
    // Scenarios
    // ---
    task automatic test_reset_bus;
        chk("idle", 32'hfff, {buffer_ctrl_first_n, buffer_ctrl_second, bank_write_strobe_n,
            row_strobe_a_n, row_strobe_b_n});
        rdreg(DBC_REG_CONFIG);
        chk("config_reset", 32'h0, rd);
        rdreg(DBC_REG_STATUS);
        chk("status_idle", 32'h0, rd);
        rdreg(8'h10);
        chk("unmapped_rdata", 32'h0, rd);
        chk("unmapped_rresp", DBC_RESP_SLVERR, rsp);
        wr(8'h10, 32'h1);
        chk("unmapped_bresp", DBC_RESP_SLVERR, rsp);
    endtask : test_reset_bus
    task automatic test_modes;
        logic w, b, ef, es;
        logic [1:0] ew;
        for (int m = 0; m < 4; m++) begin
            set_cfg(m[1:0], 3'h0);
            for (int k = 0; k < 4; k++) begin
                w = k[1];
                b = k[0];
                ef = (m == 0) ? (w | b) : (m == 1) ? b : (m == 2) ? w : 1'b0;
                es = (m == 0) ? (w | !b) : !b;
                ew = !w ? 2'h3 : (m == 3) ? 2'h0 : (b ? 2'h1 : 2'h2);
                acc(w, b, !b, 2'h0, 1'b0, 1'b0);
                chk("first_n", ef, buffer_ctrl_first_n);
                chk("second", es, buffer_ctrl_second);
                chk("wstrobe", ew, bank_write_strobe_n);
            end
            // The bank to read is announced one edge ahead, so the select leads the access.
            if (m >= 2) begin
                for (int k = 0; k < 2; k++) begin
                    @(posedge ref_clk);
                    acc_next_bank_b <= k[0];
                    acc(1'b0, k[0], k[0], 2'h0, 1'b0, 1'b0);
                    chk("drive", k[0] ? 32'h2 : 32'h1, drive);
                end
            end
        end
    endtask : test_modes
    task automatic test_rows_latch;
        logic [3:0] e;
        acc(1'b0, 1'b0, 1'b0, 2'h2, 1'b1, 1'b0);
        chk("rows_unison", 32'h0, row_strobe_a_n);
        set_cfg(2'h0, DBC_DENS_SPLIT);
        for (int k = 0; k < 4; k++) begin
            e = ~(4'h1 << k);
            acc(1'b0, k[0], 1'b0, k[1:0], 1'b1, 1'b0);
            chk("rows_split", e, k[0] ? row_strobe_b_n : row_strobe_a_n);
        end
        acc(1'b1, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0);
        chk("latch_b", 32'h2, {write_latch_enable_first_n, write_latch_enable_second_n});
        acc(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1);
        chk("latch_hold", 32'h3, {write_latch_enable_first_n, write_latch_enable_second_n});
    endtask : test_rows_latch
    task automatic test_addr;
        set_cfg(2'h0, 3'h3);
        for (int p = 1; p >= 0; p--) begin
            @(posedge ref_clk);
            acc_addr <= 32'h055e0918;
            acc_col_phase <= p[0];
            acc(1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0);
            chk("mem_addr", p ? 32'h123 : 32'habc, mem_addr);
        end
    endtask : test_addr
    initial begin
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1;
        test_reset_bus;
        test_modes;
        set_cfg(2'h0, 3'h0);
        test_rows_latch;
        test_addr;
        close_out;
    end
    // The whole run needs about a hundred cycles; the 10000-cycle limit means a hang.
    initial begin
        #40us;
        miscompares++;
        close_out;
    end
endmodule : dbc_buffer_ctrl_test
`default_nettype wire
